// ### i2m_brg.sv
// i2m_brg.sv - reloadable down counter setting the SCL timing
// assumes: load is a one-cycle pulse from the sequencer
`default_nettype none
module i2m_brg (
  input wire logic sys_clk_i, // core clock
  input wire logic rst_n_i, // async reset, active low
  i2m_brg_if.gen bus // reload and timeout
);
  logic [1:0] phase_reg;
  logic [6:0] count_reg;

  // four phases make one instruction cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  // counts on odd phases, halts at zero until reloaded
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= 7'h00;
    end else if (bus.load) begin
      count_reg <= bus.reload;
    end else if (phase_reg[0] && count_reg != 7'h00) begin
      count_reg <= count_reg - 7'h01;
    end
  end

  assign bus.zero = (count_reg == 7'h00);
endmodule : i2m_brg
`default_nettype wire

// ### i2m_brg_if.sv
// i2m_brg_if.sv - reload and timeout between sequencer and generator
// assumes: both ends on sys_clk_i
`default_nettype none
interface i2m_brg_if;
  logic load;
  logic [6:0] reload;
  logic zero;
  modport ctl (output load, output reload, input zero);
  modport gen (input load, input reload, output zero);
endinterface : i2m_brg_if
`default_nettype wire

// ### i2m_consts.svh
// i2m_consts.svh - register offsets, field positions, reset values
// assumes: included by bare name wherever the map is needed
// Notes on behaviour
// - repeat start: pull SCL low, then load generator
// - SDA released one period, then SCL released
// - SCL high: reload, both high, SDA low
// - repeat start end: clear enable, keep SDA low
// - start seen at once, event after timeout
// - repeat start request ignored while busy
// - collision: SDA low at SCL rise, early SCL fall
// - collision aborts, releases lines, clears enables
// - buffer write during repeat start sets collision
// - low five control bits locked while busy
// - buffer write sets full, starts generator
// - SDA changes after SCL fall, low/high periods
// - byte shifted out most significant bit first
// - eighth falling edge: clear full, release SDA
// - ninth falling edge samples acknowledge into bit
// - after ninth clock: event, SCL low, halt
// - write during transmit discarded, collision flag
// - receive enable honoured only when idle
// - receive: SCL toggles per rollover, SDA shifted
// - receive end: copy, full, event, idle
// - reading buffer clears full flag only when not busy
// - overflow when byte arrives with buffer full
// - write during receive discarded, collision flag
// - generator counts on phases two and four
// - acknowledge sequence drives data bit one pulse
`ifndef I2M_CONSTS_SVH
`define I2M_CONSTS_SVH
`define I2M_OFF_CTRL 8'h00
`define I2M_OFF_STAT 8'h04
`define I2M_OFF_FLAG 8'h08
`define I2M_OFF_BUF 8'h0C
`define I2M_OFF_RLD 8'h10
`define I2M_C_REPEAT_START_ENABLE 1
`define I2M_C_RECEIVE_ENABLE_BIT 3
`define I2M_C_ACK_SEQUENCE_ENABLE 4
`define I2M_C_ACK_DATA_BIT 5
`define I2M_C_ACKST 6
`define I2M_S_BF 0
`define I2M_S_START 3
`define I2M_S_STOP 4
`define I2M_S_BUSY 7
`define I2M_F_EVT 0
`define I2M_F_BCOL 1
`define I2M_F_WRITE_COLLISION_FLAG 2
`define I2M_F_OVF 3
`define I2M_RLD_RST 7'h09
`define I2M_BYTE_RST 8'h00
`define I2M_TX_LAST 4'h8
`define I2M_RX_LAST 4'h7
`define I2M_ACK_LAST 4'h0
`define I2M_HSIZE_WORD 3'h2
`endif

// ### i2m_core.sv
// i2m_core.sv - two-wire master: repeat start, transmit, receive
// assumes: AHB-Lite single word transfers, open-drain pins outside
//
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`include "i2m_consts.svh"
`default_nettype none
module i2m_core (
  input wire logic sys_clk_i, // core clock, 100 MHz
  input wire logic rst_n_i, // async reset, active low
  input wire logic hsel_i, // slave select
  input wire logic [7:0] haddr_i, // byte address
  input wire logic [1:0] htrans_i, // transfer type
  input wire logic hwrite_i, // write when high
  input wire logic [2:0] hsize_i, // word only
  input wire logic [31:0] hwdata_i, // write data
  input wire logic hready_i, // bus ready
  output logic [31:0] hrdata_o, // read data
  output logic hreadyout_o, // always ready
  output logic hresp_o, // always OKAY
  input wire logic scl_i, // clock line level
  output logic scl_o, // clock line drive value
  output logic scl_oe_o, // high while pulling clock low
  input wire logic sda_i, // data line level
  output logic sda_o, // data line drive value
  output logic sda_oe_o // high while pulling data low
);
  i2m_pkg::i2m_state_t state_reg, state_next;
  i2m_pkg::i2m_mode_t mode_reg, mode_next;
  logic [3:0] bit_reg, bit_next;
  logic scl_low_reg, scl_low_next;
  logic sda_low_reg, sda_low_next;
  logic brg_load_reg, brg_load_next;
  logic [1:0] line_s, line_q_reg;
  logic scl_s, sda_s;
  logic tmo, coll_ev, busy, fall_ev;
  logic rs_end, tx_go, tx_end8, tx_end9, rx_end, ack_end;
  logic repeat_start_enable_reg, receive_enable_bit_reg, ack_sequence_enable_reg, ack_data_bit_reg, ackst_reg;
  logic [6:0] rld_reg;
  logic [7:0] buf_reg, sr_reg;
  logic bf_reg, start_reg, stop_reg;
  logic [3:0] flag_reg, flag_set;
  logic dp_wr_reg;
  logic [7:0] dp_addr_reg;
  logic [31:0] rd_word;
  logic ap_take, rd_buf;
  logic wr_ctrl, wr_flag, wr_buf, wr_rld;

  i2m_brg_if bif ();

  //////////////////////////////////////////////////////////////////////
  // helpers

  // states that run the generator
  function automatic logic timed(input i2m_pkg::i2m_state_t s);
    timed = (s == i2m_pkg::ST_RS_SDA) || (s == i2m_pkg::ST_RS_HOLD) ||
            (s == i2m_pkg::ST_RS_DRV) || (s == i2m_pkg::ST_BIT_LO) ||
            (s == i2m_pkg::ST_BIT_HI);
  endfunction : timed

  // data-phase write strobe for one register
  function automatic logic wr_at(input logic wr, input logic [7:0] a,
                                 input logic [7:0] off);
    wr_at = wr && (a == off);
  endfunction : wr_at

  // last bit index of each engine mode
  function automatic logic [3:0] last_bit(input i2m_pkg::i2m_mode_t m);
    unique case (m)
      i2m_pkg::MD_TX: last_bit = `I2M_TX_LAST;
      i2m_pkg::MD_RX: last_bit = `I2M_RX_LAST;
      default: last_bit = `I2M_ACK_LAST;
    endcase
  endfunction : last_bit

  //////////////////////////////////////////////////////////////////////
  // line sampling and generator

  i2m_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({scl_i, sda_i}),
    .sync_o(line_s)
  );

  i2m_brg u_brg (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .bus(bif.gen)
  );

  assign scl_s = line_s[1];
  assign sda_s = line_s[0];
  assign bif.load = brg_load_reg;
  assign bif.reload = rld_reg;
  // count is stale in the cycle of a load, so ignore zero then
  assign tmo = bif.zero && !brg_load_reg;

  //////////////////////////////////////////////////////////////////////
  // event decode

  assign busy = (state_reg != i2m_pkg::ST_IDLE) || repeat_start_enable_reg ||
                receive_enable_bit_reg || ack_sequence_enable_reg;
  assign wr_ctrl = wr_at(dp_wr_reg, dp_addr_reg, `I2M_OFF_CTRL);
  assign wr_flag = wr_at(dp_wr_reg, dp_addr_reg, `I2M_OFF_FLAG);
  assign wr_buf = wr_at(dp_wr_reg, dp_addr_reg, `I2M_OFF_BUF);
  assign wr_rld = wr_at(dp_wr_reg, dp_addr_reg, `I2M_OFF_RLD);
  assign tx_go = wr_buf && !busy;
  assign rs_end = (state_reg == i2m_pkg::ST_RS_DRV) && tmo;
  // the engine pulls SCL low here: a falling edge
  assign fall_ev = (state_reg == i2m_pkg::ST_BIT_HI) && tmo && !coll_ev;
  assign tx_end8 = fall_ev && mode_reg == i2m_pkg::MD_TX &&
                   bit_reg == `I2M_RX_LAST;
  assign tx_end9 = fall_ev && mode_reg == i2m_pkg::MD_TX &&
                   bit_reg == `I2M_TX_LAST;
  assign rx_end = fall_ev && mode_reg == i2m_pkg::MD_RX &&
                  bit_reg == `I2M_RX_LAST;
  assign ack_end = fall_ev && mode_reg == i2m_pkg::MD_ACK;

  //////////////////////////////////////////////////////////////////////
  // sequencer

  // next state, line drive and bit index
  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    bit_next = bit_reg;
    scl_low_next = scl_low_reg;
    sda_low_next = sda_low_reg;
    coll_ev = 1'b0;
    unique case (state_reg)
      i2m_pkg::ST_IDLE: begin
        bit_next = 4'h0;
        if (repeat_start_enable_reg) begin
          state_next = i2m_pkg::ST_RS_LOW;
          scl_low_next = 1'b1;
        end else if (tx_go) begin
          mode_next = i2m_pkg::MD_TX;
          state_next = i2m_pkg::ST_BIT_LO;
          scl_low_next = 1'b1;
        end else if (receive_enable_bit_reg) begin
          mode_next = i2m_pkg::MD_RX;
          state_next = i2m_pkg::ST_BIT_LO;
          scl_low_next = 1'b1;
        end else if (ack_sequence_enable_reg) begin
          mode_next = i2m_pkg::MD_ACK;
          state_next = i2m_pkg::ST_BIT_LO;
          scl_low_next = 1'b1;
        end
      end
      i2m_pkg::ST_RS_LOW: begin
        if (!scl_s) begin
          state_next = i2m_pkg::ST_RS_SDA;
          sda_low_next = 1'b0;
        end
      end
      i2m_pkg::ST_RS_SDA: begin
        if (tmo && sda_s) begin
          state_next = i2m_pkg::ST_RS_REL;
          scl_low_next = 1'b0;
        end else if (tmo) begin
          coll_ev = 1'b1;
        end
      end
      i2m_pkg::ST_RS_REL: begin
        // rising SCL must see SDA high
        if (scl_s && !sda_s) begin
          coll_ev = 1'b1;
        end else if (scl_s) begin
          state_next = i2m_pkg::ST_RS_HOLD;
        end
      end
      i2m_pkg::ST_RS_HOLD: begin
        // SCL falling before SDA is driven means another master
        if (!scl_s || !sda_s) begin
          coll_ev = 1'b1;
        end else if (tmo) begin
          state_next = i2m_pkg::ST_RS_DRV;
          sda_low_next = 1'b1;
        end
      end
      i2m_pkg::ST_RS_DRV: begin
        if (tmo) begin
          state_next = i2m_pkg::ST_IDLE;
        end
      end
      i2m_pkg::ST_BIT_LO: begin
        // data moves only once SCL is seen low
        if (!scl_s) begin
          unique case (mode_reg)
            i2m_pkg::MD_TX:
              sda_low_next = (bit_reg != `I2M_TX_LAST) && !sr_reg[7];
            i2m_pkg::MD_ACK: sda_low_next = !ack_data_bit_reg;
            default: sda_low_next = 1'b0;
          endcase
        end
        if (tmo && !scl_s) begin
          state_next = i2m_pkg::ST_BIT_WT;
          scl_low_next = 1'b0;
        end
      end
      i2m_pkg::ST_BIT_WT: begin
        // a slave may stretch; high time counts from seen high
        if (scl_s) begin
          state_next = i2m_pkg::ST_BIT_HI;
        end
      end
      i2m_pkg::ST_BIT_HI: begin
        if (mode_reg == i2m_pkg::MD_ACK && ack_data_bit_reg && !sda_s) begin
          coll_ev = 1'b1;
        end else if (tmo) begin
          scl_low_next = 1'b1;
          bit_next = bit_reg + 4'h1;
          state_next = i2m_pkg::ST_BIT_LO;
          if (mode_reg == i2m_pkg::MD_TX && bit_reg == `I2M_RX_LAST) begin
            sda_low_next = 1'b0;
          end
          if (bit_reg == last_bit(mode_reg)) begin
            state_next = i2m_pkg::ST_IDLE;
            sda_low_next = 1'b0;
          end
        end
      end
      default: begin
        state_next = i2m_pkg::ST_IDLE;
      end
    endcase
    if (coll_ev) begin
      state_next = i2m_pkg::ST_IDLE;
      scl_low_next = 1'b0;
      sda_low_next = 1'b0;
    end
  end

  // reload on entry to any counting state, never on the way to idle
  assign brg_load_next = (state_next != state_reg) && timed(state_next);

  // sequencer registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= i2m_pkg::ST_IDLE;
      mode_reg <= i2m_pkg::MD_TX;
      bit_reg <= 4'h0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      brg_load_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      bit_reg <= bit_next;
      scl_low_reg <= scl_low_next;
      sda_low_reg <= sda_low_next;
      brg_load_reg <= brg_load_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // control register bits

  // enables accepted one at a time and only when nothing runs
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      repeat_start_enable_reg <= 1'b0;
      receive_enable_bit_reg <= 1'b0;
      ack_sequence_enable_reg <= 1'b0;
    end else if (wr_ctrl && !busy) begin
      repeat_start_enable_reg <= hwdata_i[`I2M_C_REPEAT_START_ENABLE];
      receive_enable_bit_reg <= hwdata_i[`I2M_C_RECEIVE_ENABLE_BIT] && !hwdata_i[`I2M_C_REPEAT_START_ENABLE];
      ack_sequence_enable_reg <= hwdata_i[`I2M_C_ACK_SEQUENCE_ENABLE] && !hwdata_i[`I2M_C_RECEIVE_ENABLE_BIT] &&
                   !hwdata_i[`I2M_C_REPEAT_START_ENABLE];
    end else begin
      if (rs_end || coll_ev) begin
        repeat_start_enable_reg <= 1'b0;
      end
      if (rx_end) begin
        receive_enable_bit_reg <= 1'b0;
      end
      if (ack_end || coll_ev) begin
        ack_sequence_enable_reg <= 1'b0;
      end
    end
  end

  // low five bits locked while busy; the ack data bit is not
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_data_bit_reg <= 1'b0;
      ackst_reg <= 1'b0;
      rld_reg <= `I2M_RLD_RST;
    end else begin
      if (wr_ctrl) begin
        ack_data_bit_reg <= hwdata_i[`I2M_C_ACK_DATA_BIT];
      end
      if (tx_end9) begin
        ackst_reg <= sda_s;
      end
      if (wr_rld) begin
        rld_reg <= hwdata_i[6:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // data path

  // a write that is refused leaves both registers untouched
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      buf_reg <= `I2M_BYTE_RST;
      sr_reg <= `I2M_BYTE_RST;
    end else if (tx_go) begin
      buf_reg <= hwdata_i[7:0];
      sr_reg <= hwdata_i[7:0];
    end else if (fall_ev && mode_reg == i2m_pkg::MD_TX) begin
      sr_reg <= {sr_reg[6:0], 1'b0};
    end else if (fall_ev && mode_reg == i2m_pkg::MD_RX) begin
      sr_reg <= {sr_reg[6:0], sda_s};
      if (rx_end) begin
        buf_reg <= {sr_reg[6:0], sda_s};
      end
    end
  end

  // buffer full: set wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bf_reg <= 1'b0;
    end else if (tx_go || rx_end) begin
      bf_reg <= 1'b1;
    end else if (tx_end8 || (rd_buf && !busy)) begin
      bf_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // flags and line watch

  always_comb begin
    flag_set = 4'h0;
    flag_set[`I2M_F_EVT] = rs_end || tx_end9 || rx_end || ack_end;
    flag_set[`I2M_F_BCOL] = coll_ev;
    flag_set[`I2M_F_WRITE_COLLISION_FLAG] = wr_buf && busy;
    flag_set[`I2M_F_OVF] = rx_end && bf_reg;
  end

  // software clears a flag by writing zero to it
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_reg <= 4'h0;
    end else if (wr_flag) begin
      flag_reg <= flag_set | (flag_reg & hwdata_i[3:0]);
    end else begin
      flag_reg <= flag_set | flag_reg;
    end
  end

  // start and stop seen on the lines, by anyone
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_q_reg <= 2'h3;
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else begin
      line_q_reg <= line_s;
      if (scl_s && line_q_reg[1] && line_q_reg[0] && !sda_s) begin
        start_reg <= 1'b1;
        stop_reg <= 1'b0;
      end else if (scl_s && line_q_reg[1] && !line_q_reg[0] && sda_s) begin
        start_reg <= 1'b0;
        stop_reg <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, read data registered

  assign ap_take = hsel_i && hready_i && htrans_i[1] &&
                   (hsize_i == `I2M_HSIZE_WORD);
  assign rd_buf = ap_take && !hwrite_i && (haddr_i == `I2M_OFF_BUF);

  // read mux; unmapped words read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (haddr_i)
      `I2M_OFF_CTRL: begin
        rd_word[`I2M_C_REPEAT_START_ENABLE] = repeat_start_enable_reg;
        rd_word[`I2M_C_RECEIVE_ENABLE_BIT] = receive_enable_bit_reg;
        rd_word[`I2M_C_ACK_SEQUENCE_ENABLE] = ack_sequence_enable_reg;
        rd_word[`I2M_C_ACK_DATA_BIT] = ack_data_bit_reg;
        rd_word[`I2M_C_ACKST] = ackst_reg;
      end
      `I2M_OFF_STAT: begin
        rd_word[`I2M_S_BF] = bf_reg;
        rd_word[`I2M_S_START] = start_reg;
        rd_word[`I2M_S_STOP] = stop_reg;
        rd_word[`I2M_S_BUSY] = busy;
      end
      `I2M_OFF_FLAG: rd_word[3:0] = flag_reg;
      `I2M_OFF_BUF: rd_word[7:0] = buf_reg;
      `I2M_OFF_RLD: rd_word[6:0] = rld_reg;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // address phase capture
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      hrdata_o <= 32'h0000_0000;
    end else begin
      dp_wr_reg <= ap_take && hwrite_i;
      if (ap_take) begin
        dp_addr_reg <= haddr_i;
      end
      if (ap_take && !hwrite_i) begin
        hrdata_o <= rd_word;
      end
    end
  end

  // fixed answers and pin drive levels, all from flops
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  assign scl_oe_o = scl_low_reg;
  assign sda_oe_o = sda_low_reg;

  //////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  rs_load_a: assert property (
    state_reg == i2m_pkg::ST_RS_LOW && !scl_s |=>
      brg_load_reg && scl_oe_o && !sda_oe_o)
    else $error("repeat start did not load generator");

  rs_rel_a: assert property (
    state_reg == i2m_pkg::ST_RS_SDA && tmo && sda_s |=>
      !scl_oe_o && !sda_oe_o ##0 state_reg == i2m_pkg::ST_RS_REL)
    else $error("SCL not released after SDA high period");

  rs_drive_a: assert property (
    state_reg == i2m_pkg::ST_RS_HOLD && tmo && scl_s && sda_s |=>
      sda_oe_o && !scl_oe_o && brg_load_reg)
    else $error("SDA not driven low with SCL high");

  rs_end_a: assert property (
    rs_end |=> !repeat_start_enable_reg && sda_oe_o && !brg_load_reg &&
      flag_reg[`I2M_F_EVT])
    else $error("repeat start end wrong");

  rs_coll_a: assert property (
    state_reg == i2m_pkg::ST_RS_HOLD && !scl_s |=>
      flag_reg[`I2M_F_BCOL] && !scl_oe_o && !sda_oe_o && !repeat_start_enable_reg)
    else $error("early SCL fall not seen as collision");

  write_collision_flag_set_a: assert property (
    wr_buf && busy |=> flag_reg[`I2M_F_WRITE_COLLISION_FLAG] && $stable(buf_reg))
    else $error("refused buffer write not flagged");

  ctrl_lock_a: assert property (
    wr_ctrl && repeat_start_enable_reg |=>
      !receive_enable_bit_reg && !ack_sequence_enable_reg)
    else $error("control write taken while busy");

  tx_eight_a: assert property (
    tx_end8 |=> !bf_reg && !sda_oe_o ##1 !sda_oe_o)
    else $error("eighth fall did not release SDA");

  ack_stat_a: assert property (
    tx_end9 |=> ackst_reg == $past(sda_s) && flag_reg[`I2M_F_EVT] &&
      scl_oe_o && state_reg == i2m_pkg::ST_IDLE)
    else $error("acknowledge not captured");

  rx_done_a: assert property (
    rx_end |=> bf_reg && !receive_enable_bit_reg && scl_oe_o &&
      state_reg == i2m_pkg::ST_IDLE && !brg_load_reg)
    else $error("receive end wrong");

  rx_ovf_a: assert property (
    rx_end && bf_reg |=> flag_reg[`I2M_F_OVF])
    else $error("overflow not flagged");

  rs_done_c: cover property (rs_end);
  tx_nack_c: cover property (tx_end9 && sda_s);
  rx_ovf_c: cover property (rx_end && bf_reg);
  rs_coll_c: cover property (coll_ev && repeat_start_enable_reg);
endmodule : i2m_core
`default_nettype wire

// ### i2m_pkg.sv
// i2m_pkg.sv - state and mode types of the two-wire master
// assumes: compiled before the interface and the modules
`default_nettype none
package i2m_pkg;
  // sequencer states: repeat start steps, then a generic bit engine
  typedef enum logic [3:0] {
    ST_IDLE, ST_RS_LOW, ST_RS_SDA, ST_RS_REL, ST_RS_HOLD, ST_RS_DRV,
    ST_BIT_LO, ST_BIT_WT, ST_BIT_HI
  } i2m_state_t;
  // what the bit engine is doing
  typedef enum logic [1:0] {MD_TX, MD_RX, MD_ACK} i2m_mode_t;
endpackage : i2m_pkg
`default_nettype wire

// ### i2m_slave.sv
// i2m_slave.sv - far-side target on the two-wire bus
// assumes: bench builds the open-drain lines with pull-ups
`default_nettype none
module i2m_slave (
  input wire logic scl_i, // bus clock level
  input wire logic clr_i, // restart the fall count
  input wire logic rx_i, // high: we send a byte
  input wire logic [7:0] dat_i, // byte to send, msb first
  output logic sda_oe_o // high pulls data low
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // count clock falls; data moves only while the clock is low
  always @(negedge scl_i or posedge clr_i) begin
    if (clr_i) cnt <= 0;
    else cnt <= cnt + 1;
  end
  // ack in the ninth bit time, else release to pull-up
  always_comb begin
    if (rx_i) sda_oe_o = (cnt < 8) && !dat_i[3'h7 - cnt[2:0]];
    else sda_oe_o = (cnt == 9);
  end
endmodule : i2m_slave
`default_nettype wire

// ### i2m_sync.sv
// i2m_sync.sv - two-flop synchroniser for the bus lines
// assumes: inputs are asynchronous pins, idle high
`default_nettype none
module i2m_sync (
  input wire logic sys_clk_i, // core clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [1:0] async_i, // raw pins
  output logic [1:0] sync_o // safe copies
);
  logic [1:0] meta_reg;

  // reset to released bus so no false edge follows reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 2'h3;
      sync_o <= 2'h3;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule : i2m_sync
`default_nettype wire

// ### test_i2c_master_rstart_tx_rx.sv
// test_i2c_master_rstart_tx_rx.sv - register-level bench of the core
// assumes: i2m_core and i2m_slave compiled first
`default_nettype none
module test_i2c_master_rstart_tx_rx;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, clr = 0, rx = 0;
  logic xscl = 0; // a second master pulling SCL low
  logic [7:0] haddr = 8'h00, sdat = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, q;
  logic [8:0] mon = 9'h000;
  wire logic hrdy, scl_oe, sda_oe, s_oe, scl, sda;
  wire logic hresp, scl_d, sda_d;
  wire logic [31:0] hrdata;
  int err_count = 0, checked = 0;
  // open-drain lines with pull-ups
  assign scl = !(scl_oe || xscl);
  assign sda = !(sda_oe || s_oe);
  always #5 clk = !clk;
  i2m_core uut (.sys_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .scl_i(scl),
    .scl_o(scl_d), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_d),
    .sda_oe_o(sda_oe));
  i2m_slave slv (.scl_i(scl), .clr_i(clr), .rx_i(rx), .dat_i(sdat),
    .sda_oe_o(s_oe));
  // data bits seen at each clock rise
  always @(posedge scl or posedge clr) begin
    if (clr) mon <= 9'h000;
    else mon <= {mon[7:0], sda};
  end
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [31:0] e,
                    input string n);
    bus(a, 1'b0, 32'h0);
    chk(n, q, e);
  endtask : rc
  task automatic bf(input logic [31:0] e, input string n);
    bus(8'h04, 1'b0, 32'h0);
    chk(n, q & 32'h1, e);
  endtask : bf
  // poll busy; the limit of 3000 polls covers a stuck sequencer
  task automatic idle();
    int i;
    i = 0;
    do begin
      bus(8'h04, 1'b0, 32'h0);
      i++;
    end while (q[7] === 1'b1 && i < 3000);
    // still busy or unknown at the limit: a hang, end the run
    if (q[7] !== 1'b0) begin
      err_count++;
      print_verdict();
    end
  endtask : idle
  task automatic arm(input logic r, input logic [7:0] d);
    bus(8'h08, 1'b1, 32'h0);
    sdat <= d;
    rx <= r;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask : arm
  task automatic rxb(input logic [7:0] d);
    arm(1'b1, d);
    bus(8'h00, 1'b1, 32'h8);
    bus(8'h0C, 1'b1, 32'hFF); // dropped
    idle();
  endtask : rxb
  task automatic print_verdict();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // cut a hang short
  initial begin
    #500000;
    err_count++;
    print_verdict();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(8'h00, 32'h0, "ctrl rst");
    rc(8'h10, 32'h9, "reload rst");
    rc(8'h14, 32'h0, "unmapped");
    chk("fixed outs", {29'h0, hresp, scl_d, sda_d}, 32'h0);
    bus(8'h10, 1'b1, 32'h4);
    bus(8'h00, 1'b1, 32'h2);
    bus(8'h0C, 1'b1, 32'hA5);
    bus(8'h00, 1'b1, 32'h8);
    rc(8'h00, 32'h2, "ctrl busy");
    idle();
    rc(8'h00, 32'h0, "rs ctrl");
    rc(8'h04, 32'h8, "rs status");
    rc(8'h08, 32'h5, "rs flags");
    rc(8'h0C, 32'h0, "rs buf");
    chk("rs lines", {30'h0, scl_oe, sda_oe}, 32'h1);
    arm(1'b0, 8'h00);
    bus(8'h0C, 1'b1, 32'hA5);
    bf(32'h1, "tx bf");
    bus(8'h0C, 1'b1, 32'h3C);
    bus(8'h00, 1'b1, 32'h2);
    idle();
    chk("wire byte", {23'h0, mon}, 32'h14A);
    rc(8'h00, 32'h0, "ack stat");
    bf(32'h0, "tx bf end");
    rc(8'h08, 32'h5, "tx flags");
    chk("scl hold", {31'h0, scl_oe}, 32'h1);
    rxb(8'h5A);
    rc(8'h00, 32'h0, "rx ctrl");
    rc(8'h08, 32'h5, "rx flags");
    bf(32'h1, "rx bf");
    rc(8'h0C, 32'h5A, "rx byte");
    bf(32'h0, "rx bf read");
    rxb(8'hC3);
    rxb(8'h3C);
    rc(8'h08, 32'hD, "overflow");
    // not-acknowledge then acknowledge, one clock pulse each
    arm(1'b1, 8'hFF);
    bus(8'h00, 1'b1, 32'h30);
    idle();
    bus(8'h00, 1'b1, 32'h10);
    idle();
    chk("ack bits", {23'h0, mon}, 32'h2);
    rc(8'h08, 32'h1, "ack flags");
    rc(8'h00, 32'h0, "ack ctrl");
    // second master pulls SCL low while both lines must stay high
    bus(8'h00, 1'b1, 32'h2);
    @(posedge scl);
    repeat (5) @(posedge clk);
    xscl <= 1'b1;
    idle();
    xscl <= 1'b0;
    rc(8'h08, 32'h3, "coll flags");
    rc(8'h00, 32'h0, "coll ctrl");
    chk("coll lines", {30'h0, scl_oe, sda_oe}, 32'h0);
    print_verdict();
  end
endmodule : test_i2c_master_rstart_tx_rx
`default_nettype wire
